/* src/port_a_pfc_defs.vh */
// port a pin function controller: register offsets, reset values, field codes
// assumes inclusion by the port a controller, checker and bench files
`ifndef PORT_A_PIN_FUNCTION_DEFS_VH
`define PORT_A_PIN_FUNCTION_DEFS_VH

// apb byte offsets, one aligned word each
`define PA_OFF_DIR_HIGH 8'h00
`define PA_OFF_DIR_LOW 8'h04
`define PA_OFF_FUNC_HIGH 8'h08
`define PA_OFF_FUNC_LOW2 8'h0c
`define PA_OFF_FUNC_LOW1 8'h10
`define PA_OFF_DATA 8'h14

// reset values
`define PA_RST_DIR_HIGH 16'h0000
`define PA_RST_DIR_LOW 16'h0000
`define PA_RST_FUNC 16'h0000
`define PA_RST_DATA 16'h0000

// writable bit masks
`define PA_MASK_FULL 16'hffff
`define PA_MASK_DIR_HIGH 16'h00ff
`define PA_MASK_FUNC_SMALL 16'h55ff

// function field codes, two bits per pin
`define PA_FSEL_GPIO 2'h0
`define PA_FSEL_SERIAL 2'h1

// pins that carry the serial clocks
`define PA_PIN_SERIAL_CLOCK_0 2
`define PA_PIN_SERIAL_CLOCK_1 5

`endif

/* src/pin_sync3.v */
// three-stage input synchroniser for asynchronous pin levels
// assumes: inputs change freely relative to clk; output accepted when stages 2 and 3 agree
module pin_sync3 #(
    parameter WIDTH = 24
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // asynchronous levels in, settled levels out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] level
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;

    // stage1 feeds only stage2; a bit counts once stages 2 and 3 agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            level <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

endmodule // pin_sync3

/* src/port_a_pin_direction_function.v */
// port a direction and function selection, 24 multiplexed pins, apb slave
// assumes: one clock pclk, async active-low presetn, pads resolved outside
// from pin_out/pin_oe, peripherals drive alt_out/alt_oe and read alt_in
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "port_a_pfc_defs.vh"

// How it works
// - direction bit 1 drives the pin out, 0 leaves it an input
// - two 16-bit direction registers map in order onto pins 23 down to 0
// - low direction applies for gpio pins 15..0 or serial clock pins
// - high direction applies only while pins 23..16 are gpio
// - high direction bits 15..8 read zero; software writes zero there
// - smaller variant: high direction bits 7..0 control no pin
// - reset clears both direction registers, every pin an input
// - three 16-bit control registers pick each pin's function
// - smaller variant: high control register bits 15, 13, 11, 9 read zero
module port_a_pin_direction_function #(
    parameter SMALL_VARIANT = 0,
    parameter PINS = 24,
    parameter ADDR_WIDTH = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // port a pads
    input wire [PINS-1:0] pin_in,
    output reg [PINS-1:0] pin_out,
    output reg [PINS-1:0] pin_oe,
    // on-chip peripherals sharing the pins
    input wire [PINS-1:0] alt_out,
    input wire [PINS-1:0] alt_oe,
    output wire [PINS-1:0] alt_in
);

    // software-visible state
    reg [15:0] port_a_direction_low;
    reg [15:0] port_a_direction_high;
    reg [15:0] port_a_function_low1;
    reg [15:0] port_a_function_low2;
    reg [15:0] port_a_function_high;
    reg [15:0] port_a_data;

    // settled pin levels
    wire [PINS-1:0] pin_level;

    // bus decode
    wire setup_phase;
    wire write_now;
    wire [2:0] slot;
    reg addr_hit;
    reg [15:0] read_word;

    // next pad values
    reg [PINS-1:0] next_pin_out;
    reg [PINS-1:0] next_pin_oe;
    reg [1:0] sel;
    integer i;

    // control-register mask: bits 15, 13, 11, 9 reserved on the smaller variant
    localparam [15:0] FUNC_HIGH_MASK =
        (SMALL_VARIANT != 0) ? `PA_MASK_FUNC_SMALL : `PA_MASK_FULL;

    // register slots behind the apb addresses
    localparam [2:0] SLOT_DIR_HIGH = 3'h0;
    localparam [2:0] SLOT_DIR_LOW = 3'h1;
    localparam [2:0] SLOT_FUNC_HIGH = 3'h2;
    localparam [2:0] SLOT_FUNC_LOW2 = 3'h3;
    localparam [2:0] SLOT_FUNC_LOW1 = 3'h4;
    localparam [2:0] SLOT_DATA = 3'h5;
    localparam [2:0] SLOT_NONE = 3'h7;

    // merge byte lanes 0 and 1 of a write into a 16-bit register
    function [15:0] merge_write;
        input [15:0] old;
        input [31:0] wdata;
        input [3:0] strb;
        input [15:0] mask;
        reg [15:0] lanes;
        begin
            lanes = old;
            if (strb[0]) begin
                lanes[7:0] = wdata[7:0];
            end
            if (strb[1]) begin
                lanes[15:8] = wdata[15:8];
            end
            merge_write = lanes & mask;
        end
    endfunction

    // two-bit function field of one pin, eight pins per control register
    function [1:0] pin_function;
        input [15:0] f_low1;
        input [15:0] f_low2;
        input [15:0] f_high;
        input integer idx;
        reg [15:0] word;
        integer pos;
        begin
            if (idx < 8) begin
                word = f_low1;
            end else if (idx < 16) begin
                word = f_low2;
            end else begin
                word = f_high;
            end
            pos = (idx % 8) * 2;
            pin_function = word[pos +: 2];
        end
    endfunction

    // whether a pin is one of the two serial clock pins
    function is_serial_clock;
        input integer idx;
        begin
            is_serial_clock = (idx == `PA_PIN_SERIAL_CLOCK_0) ||
                (idx == `PA_PIN_SERIAL_CLOCK_1);
        end
    endfunction

    // one address decode shared by the read mux and the write path,
    // so the two register maps cannot drift apart
    function [2:0] reg_slot;
        input [ADDR_WIDTH-1:0] addr;
        begin
            case (addr)
                `PA_OFF_DIR_HIGH: begin
                    reg_slot = SLOT_DIR_HIGH;
                end
                `PA_OFF_DIR_LOW: begin
                    reg_slot = SLOT_DIR_LOW;
                end
                `PA_OFF_FUNC_HIGH: begin
                    reg_slot = SLOT_FUNC_HIGH;
                end
                `PA_OFF_FUNC_LOW2: begin
                    reg_slot = SLOT_FUNC_LOW2;
                end
                `PA_OFF_FUNC_LOW1: begin
                    reg_slot = SLOT_FUNC_LOW1;
                end
                `PA_OFF_DATA: begin
                    reg_slot = SLOT_DATA;
                end
                default: begin
                    reg_slot = SLOT_NONE;
                end
            endcase
        end
    endfunction

    // pin levels cross from the pads into pclk
    pin_sync3 #(
        .WIDTH(PINS)
    ) u_pin_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(pin_in),
        .level(pin_level)
    );

    // peripherals see the settled level of every pin
    assign alt_in = pin_level;

    // a write lands only at the access edge where pready is sampled high
    assign setup_phase = psel && !penable;
    assign write_now = psel && penable && pready && pwrite;
    assign slot = reg_slot(paddr);

    // read mux over the decoded slot, reserved bits forced low
    always @* begin
        addr_hit = (slot != SLOT_NONE);
        read_word = 16'h0000;
        case (slot)
            SLOT_DIR_HIGH: begin
                read_word = port_a_direction_high & `PA_MASK_DIR_HIGH;
            end
            SLOT_DIR_LOW: begin
                read_word = port_a_direction_low;
            end
            SLOT_FUNC_HIGH: begin
                read_word = port_a_function_high & FUNC_HIGH_MASK;
            end
            SLOT_FUNC_LOW2: begin
                read_word = port_a_function_low2;
            end
            SLOT_FUNC_LOW1: begin
                read_word = port_a_function_low1;
            end
            SLOT_DATA: begin
                read_word = pin_level[15:0];
            end
            default: begin
                read_word = 16'h0000;
            end
        endcase
    end

    // one wait-free access phase: answer prepared during setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                pslverr <= !addr_hit;
                prdata <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    // register writes; unmapped writes are dropped and flagged by pslverr
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_direction_low <= `PA_RST_DIR_LOW;
            port_a_direction_high <= `PA_RST_DIR_HIGH;
            port_a_function_low1 <= `PA_RST_FUNC;
            port_a_function_low2 <= `PA_RST_FUNC;
            port_a_function_high <= `PA_RST_FUNC;
            port_a_data <= `PA_RST_DATA;
        end else if (write_now) begin
            case (slot)
                SLOT_DIR_HIGH: begin
                    // upper byte never stored, so it reads zero
                    port_a_direction_high <= merge_write(port_a_direction_high,
                        pwdata, pstrb, `PA_MASK_DIR_HIGH);
                end
                SLOT_DIR_LOW: begin
                    port_a_direction_low <= merge_write(port_a_direction_low,
                        pwdata, pstrb, `PA_MASK_FULL);
                end
                SLOT_FUNC_HIGH: begin
                    port_a_function_high <= merge_write(port_a_function_high,
                        pwdata, pstrb, FUNC_HIGH_MASK);
                end
                SLOT_FUNC_LOW2: begin
                    port_a_function_low2 <= merge_write(port_a_function_low2,
                        pwdata, pstrb, `PA_MASK_FULL);
                end
                SLOT_FUNC_LOW1: begin
                    port_a_function_low1 <= merge_write(port_a_function_low1,
                        pwdata, pstrb, `PA_MASK_FULL);
                end
                SLOT_DATA: begin
                    port_a_data <= merge_write(port_a_data, pwdata, pstrb,
                        `PA_MASK_FULL);
                end
                default: begin
                    port_a_data <= port_a_data;
                end
            endcase
        end
    end

    // per-pin function and direction resolution
    always @* begin
        next_pin_out = {PINS{1'b0}};
        next_pin_oe = {PINS{1'b0}};
        sel = `PA_FSEL_GPIO;
        for (i = 0; i < PINS; i = i + 1) begin
            sel = pin_function(port_a_function_low1, port_a_function_low2,
                port_a_function_high, i);
            if (i < 16) begin
                if (sel == `PA_FSEL_GPIO) begin
                    // gpio: low direction bit decides, data register drives
                    next_pin_oe[i] = port_a_direction_low[i];
                    next_pin_out[i] = port_a_data[i];
                end else if (is_serial_clock(i) && sel == `PA_FSEL_SERIAL) begin
                    // serial clock: direction still from the low register
                    next_pin_oe[i] = port_a_direction_low[i];
                    next_pin_out[i] = alt_out[i];
                end else begin
                    // other peripheral owns direction; low register ignored
                    next_pin_oe[i] = alt_oe[i];
                    next_pin_out[i] = alt_out[i];
                end
            end else if (SMALL_VARIANT != 0) begin
                // upper group has no pads here; bits stay stored but idle
                next_pin_oe[i] = 1'b0;
                next_pin_out[i] = 1'b0;
            end else if (sel == `PA_FSEL_GPIO) begin
                // high direction only while the upper pins are gpio
                next_pin_oe[i] = port_a_direction_high[i-16];
                next_pin_out[i] = 1'b0;
            end else begin
                next_pin_oe[i] = alt_oe[i];
                next_pin_out[i] = alt_out[i];
            end
        end
    end

    // registered pads: a write shows one edge later, whole word at once,
    // so pins the write leaves alone see no intermediate value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= {PINS{1'b0}};
            pin_out <= {PINS{1'b0}};
        end else begin
            pin_oe <= next_pin_oe;
            pin_out <= next_pin_out;
        end
    end

endmodule // port_a_pin_direction_function

/* bench/pfc_checker.sv */
// assertions for the port a direction and function block, bound to every instance
// assumes: one apb access cycle per setup, pads follow registers one edge later
`include "port_a_pfc_defs.vh"
module pin_function_checker #(
    parameter SMALL_VARIANT = 0,
    parameter PINS = 24,
    parameter ADDR_WIDTH = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pads
    input wire [PINS-1:0] pin_out,
    input wire [PINS-1:0] pin_oe,
    input wire [PINS-1:0] alt_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed transfers, seen at the edge that ends them
    wire acc_wr = psel && penable && pwrite && pready;
    wire acc_rd = psel && penable && !pwrite && pready;
    property p_ready_after_setup; psel && !penable |=> pready; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held too long");
    property p_rdata_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper data set");
    property p_err_ready; pslverr |-> pready && psel && penable; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error outside access");
    property p_dir_high_rsv; acc_rd && paddr == `PA_OFF_DIR_HIGH |-> prdata[15:8] == 8'h00; endproperty
    a_dir_high_rsv: assert property (p_dir_high_rsv) else $error("reserved bits read 1");
    property p_reset_pins; $rose(presetn) |-> pin_oe == '0 && pin_out == '0; endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins driven at reset");
    // enables move only after a write or a peripheral enable change
    property p_oe_cause;
        $changed(pin_oe) |-> $past(acc_wr, 2) || ($past(alt_oe, 1) != $past(alt_oe, 2));
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("enable changed alone");
    property p_small_upper; (SMALL_VARIANT != 0) |-> pin_oe[PINS-1:16] == '0; endproperty
    a_small_upper: assert property (p_small_upper) else $error("small upper pin driven");
    property p_small_func_rsv;
        (SMALL_VARIANT != 0) && acc_rd && paddr == `PA_OFF_FUNC_HIGH |->
            (prdata[15:0] & 16'haa00) == 16'h0000;
    endproperty
    a_small_func_rsv: assert property (p_small_func_rsv) else $error("reserved read 1");
endmodule // pin_function_checker

bind port_a_pin_direction_function pin_function_checker #(.SMALL_VARIANT(SMALL_VARIANT),
    .PINS(PINS),
    .ADDR_WIDTH(ADDR_WIDTH)) u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe), .alt_oe(alt_oe));

/* bench/tb_port_a_pin_direction_function.sv */
// self-checking bench for the port a direction and function block
// assumes: full and small variants share one apb master; reads checked on both
`include "port_a_pfc_defs.vh"
module tb_port_a_pin_direction_function;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, prdata_s;
    logic [3:0] pstrb;
    logic [23:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, pin_oe_s;
    logic [15:0] dl, dh, f1, f2, fh, dat;
    logic [32:0] exp_q[$];
    logic [32:0] mon_e;
    int error_cnt = 0, check_count = 0, cycles = 0;

    port_a_pin_direction_function #(.SMALL_VARIANT(0)) dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in));
    port_a_pin_direction_function #(.SMALL_VARIANT(1)) dut_small (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_s), .pready(), .pslverr(),
        .pin_in(pin_in),
        .pin_out(), .pin_oe(pin_oe_s), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in());

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task test_done();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // whole run is about two hundred cycles; a hang ends here
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            chk(32'h0, 32'h1);
            test_done();
        end
    end

    // answers taken at the edge that ends the access, as the master does
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1) begin
            mon_e = exp_q.pop_front();
            chk(pslverr, mon_e[32]);
            if (!pwrite) chk(prdata, {16'h0000, mon_e[15:0]});
            if (!pwrite) chk(prdata_s, {16'h0000, mon_e[15:0]});
        end
    end

    // request held until ready is seen high, released at that edge
    task apb(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        pstrb <= 4'h3;
        exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected pads from the register copies and the peripheral inputs
    task check_pins();
        logic [47:0] fn;
        logic [23:0] eo, ev;
        logic [1:0] c;
        fn = {fh, f2, f1};
        for (int n = 0; n < 24; n++) begin
            c = fn[2*n+:2];
            if (c == `PA_FSEL_GPIO) begin
                eo[n] = (n < 16) ? dl[n] : dh[n-16];
                ev[n] = (n < 16) ? dat[n] : 1'b0;
            end else begin
                eo[n] = (c == `PA_FSEL_SERIAL && (n == 2 || n == 5)) ? dl[n] : alt_oe[n];
                ev[n] = alt_out[n];
            end
        end
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(pin_oe, eo);
        chk(pin_out, ev);
        chk(pin_oe_s[23:16], 8'h00);
        chk(alt_in, pin_in);
    endtask

    initial begin
        void'($urandom(80));
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {dl, dh, f1, f2, fh, dat} = '0;
        alt_out = '0;
        alt_oe = '0;
        pin_in = $urandom;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 5; a++) apb(8'(4 * a), 1'b0, 16'h0, 33'h0);
        check_pins();
        for (int k = 0; k < 4; k++) begin
            dl = $urandom;
            dh = {8'h00, 8'($urandom)};
            f1 = (k == 0) ? 16'h0412 : 16'($urandom);
            f2 = $urandom;
            fh = $urandom & 16'h55ff;
            dat = $urandom;
            @(posedge pclk);
            alt_oe <= 24'($urandom);
            alt_out <= 24'($urandom);
            pin_in <= 24'($urandom);
            apb(`PA_OFF_DIR_LOW, 1'b1, dl, 33'h0);
            apb(`PA_OFF_DIR_HIGH, 1'b1, dh, 33'h0);
            apb(`PA_OFF_FUNC_LOW1, 1'b1, f1, 33'h0);
            apb(`PA_OFF_FUNC_LOW2, 1'b1, f2, 33'h0);
            apb(`PA_OFF_FUNC_HIGH, 1'b1, fh, 33'h0);
            apb(`PA_OFF_DATA, 1'b1, dat, 33'h0);
            apb(`PA_OFF_DIR_LOW, 1'b0, 16'h0, {17'h0, dl});
            apb(`PA_OFF_DIR_HIGH, 1'b0, 16'h0, {17'h0, dh});
            apb(`PA_OFF_FUNC_LOW1, 1'b0, 16'h0, {17'h0, f1});
            apb(`PA_OFF_FUNC_LOW2, 1'b0, 16'h0, {17'h0, f2});
            apb(`PA_OFF_FUNC_HIGH, 1'b0, 16'h0, {17'h0, fh});
            apb(`PA_OFF_DATA, 1'b0, 16'h0, {17'h0, pin_in[15:0]});
            check_pins();
        end
        // unmapped place: refused, nothing stored
        apb(8'h18, 1'b1, 16'hffff, {1'b1, 32'h0});
        apb(8'h18, 1'b0, 16'h0, {1'b1, 32'h0});
        apb(`PA_OFF_DIR_LOW, 1'b0, 16'h0, {17'h0, dl});
        check_pins();
        test_done();
    end
endmodule // tb_port_a_pin_direction_function
